// >>> logic/nibble_pkg.sv
package nibble_pkg;
  localparam int DATA_W = 4;
  localparam int MEM_AW = 7;
  localparam int HL_W = 8;
  localparam int TBL_W = 8;
  localparam int CNT_W = 16;
  localparam int ADR_W = 8;

  // Register byte offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_HL = 8'h08;
  localparam logic [7:0] REG_ENABLE = 8'h0C;
  localparam logic [7:0] REG_WAKE = 8'h10;

  // Command word fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_ARG_LSB = 8;
  localparam int CMD_IMM_LSB = 16;

  // Status word fields
  localparam int STS_AC_LSB = 0;
  localparam int STS_BUSY = 4;
  localparam int STS_HALT = 5;
  localparam int STS_STOP = 6;
  localparam int STS_SVC = 7;

  // Enable word fields
  localparam int EN_IRQ_LSB = 0;
  localparam int EN_HALT_LSB = 8;
  localparam int EN_SCA = 16;
  localparam int EN_SRE = 17;

  // Operand bit positions
  localparam int SRC_PIN_BIT = 0;
  localparam int SRC_PRE_BIT = 3;
  localparam int SRC_TMR_BIT = 4;
  localparam int SRC_CNT_BIT = 6;
  localparam int WAKE_PIN_SEL_BIT = 4;
  localparam logic [7:0] IRQ_EN_MASK = 8'h59;
  localparam logic [7:0] HALT_EN_MASK = 8'h58;
  localparam logic [7:0] EN_RESET = 8'h00;

  // Wake-cause flag positions in the wake word
  localparam int WK_F0 = 0;
  localparam int WK_F2 = 2;
  localparam int WK_F6 = 6;
  localparam int WK_F7 = 7;
  localparam int WK_F9 = 9;

  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_ORI = 5'h01, OP_ORI_S = 5'h02, OP_STA = 5'h03,
    OP_STA_HL = 5'h04, OP_LDS = 5'h05, OP_LDA = 5'h06, OP_LDA_HL = 5'h07,
    OP_LDH = 5'h08, OP_LDH_S = 5'h09, OP_LDL = 5'h0A, OP_LDL_S = 5'h0B,
    OP_COUNTER_NIBBLE0_READ = 5'h0C, OP_COUNTER_NIBBLE1_READ = 5'h0D, OP_COUNTER_NIBBLE2_READ = 5'h0E, OP_COUNTER_NIBBLE3_READ = 5'h0F,
    OP_HALT = 5'h10, OP_STOP = 5'h11, OP_SCA = 5'h12, OP_SIE = 5'h13,
    OP_SHE = 5'h14, OP_SRE = 5'h15, OP_MSB = 5'h16, OP_MSC = 5'h17,
    OP_MCX = 5'h18
  } op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_FETCH = 3'b001, ST_EXEC = 3'b010,
    ST_HALT = 3'b011, ST_SERVICE = 3'b100, ST_STOP = 3'b101
  } state_t;
endpackage

// >>> logic/nibble_data_mem.sv
`timescale 1ns/100ps
module nibble_data_mem #(
  parameter int AW = 7,
  parameter int DW = 4
) (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
    rdata_o <= mem[addr_i];
  end
endmodule // nibble_data_mem

// >>> logic/nibble_exec.sv
// Design decisions made here: the placing of the registers and the Wishbone register port.
`timescale 1ns/100ps
// Overview of operation
// - OR immediate with memory nibble into result
// - Starred OR also writes result back to memory
// - Store result to direct or indexed memory
// - Load immediate into result and memory
// - Direct load copies memory nibble to result
// - Indexed load copies memory nibble to result
// - Table high nibble to memory and result
// - Starred table high read increments index
// - Table low read, starred form increments index
// - Counter read returns selected nibble in order
// - Halt until enabled pin or source fires
// - Stop mode stops oscillator until release
// - Halt wake source uses operand bit four
// - Interrupt enables from bits 0,3,4,6
// - Halt release enables from bits 3,4,6
// - Stop wake enable from operand bit four
// - Flag group B reads flag 2 only
// - Flag group C: flag 7, prescaler stage
// - Prescaler release sets wake flag 7
// - Further read: flags 9, 0, 6
module nibble_exec (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [nibble_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [nibble_pkg::HL_W-1:0] table_addr_o,
  input wire logic [nibble_pkg::TBL_W-1:0] table_data_i,
  input wire logic [nibble_pkg::CNT_W-1:0] counter_i,
  input wire logic prescaler_stage15_bit_i,
  input wire logic prescaler_ovf_i,
  input wire logic timer_unf_i,
  input wire logic counter_ovf_i,
  input wire logic wake_input_pin_i,
  input wire logic irq_return_i,
  output logic irq_req_o,
  output logic osc_run_o
);
  import nibble_pkg::*;

  function automatic logic [DATA_W-1:0] nib(input logic [CNT_W-1:0] c,
                                            input logic [1:0] i);
    nib = c[i*DATA_W +: DATA_W];
  endfunction

  state_t state;
  op_t op;
  logic [HL_W-1:0] arg;
  logic [DATA_W-1:0] imm;
  logic [DATA_W-1:0] four_bit_result_register;
  logic [HL_W-1:0] index_pointer;
  logic [HL_W-1:0] irq_en;
  logic [HL_W-1:0] halt_en;
  logic sca_pin;
  logic stop_wake_enable_flag;
  logic wake_cause_flag_0;
  logic wake_cause_flag_2;
  logic wake_cause_flag_6;
  logic wake_cause_flag_7;
  logic wake_cause_flag_9;
  logic pin_s1;
  logic pin_s2;
  logic pin_s3;
  logic [MEM_AW-1:0] mem_addr;
  logic mem_we;
  logic [DATA_W-1:0] mem_wdata;
  logic [DATA_W-1:0] mem_rd;
  logic [DATA_W-1:0] next_ac;
  logic load_ac;
  logic hl_inc;
  logic hit_pin;
  logic hit_pre;
  logic hit_tmr;
  logic hit_cnt;
  logic release_halt;
  logic to_service;
  logic bus_req;
  logic bus_wr;
  logic cmd_take;
  op_t cmd_op;

  assign bus_req = wb_cyc_i & wb_stb_i;
  assign bus_wr = bus_req & wb_we_i & wb_ack_o;
  assign cmd_op = op_t'(wb_dat_i[CMD_OP_LSB +: $bits(op_t)]);
  assign cmd_take = bus_wr && wb_adr_i == REG_CMD && wb_sel_i == 4'hF &&
                    state == ST_IDLE;

  // Wake pin crosses in from outside
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_s3 <= 1'b0;
    end else begin
      pin_s1 <= wake_input_pin_i;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  assign hit_pin = sca_pin & (pin_s2 ^ pin_s3);
  assign hit_pre = prescaler_ovf_i & halt_en[SRC_PRE_BIT];
  assign hit_tmr = timer_unf_i & halt_en[SRC_TMR_BIT];
  assign hit_cnt = counter_ovf_i & halt_en[SRC_CNT_BIT];
  assign release_halt = hit_pin | hit_pre | hit_tmr | hit_cnt;
  assign to_service = (hit_pin & irq_en[SRC_PIN_BIT]) |
                      (hit_pre & irq_en[SRC_PRE_BIT]) |
                      (hit_tmr & irq_en[SRC_TMR_BIT]) |
                      (hit_cnt & irq_en[SRC_CNT_BIT]);

  // Memory addressing: indexed forms use the index pointer
  always_comb begin
    if (op == OP_STA_HL || op == OP_LDA_HL) begin
      mem_addr = index_pointer[MEM_AW-1:0];
    end else begin
      mem_addr = arg[MEM_AW-1:0];
    end
  end

  // Result path; nothing here touches a carry
  always_comb begin
    next_ac = four_bit_result_register;
    load_ac = 1'b0;
    mem_we = 1'b0;
    hl_inc = 1'b0;
    if (state == ST_EXEC) begin
      case (op)
        OP_ORI, OP_ORI_S: begin
          next_ac = mem_rd | imm;
          load_ac = 1'b1;
          mem_we = (op == OP_ORI_S);
        end
        OP_STA, OP_STA_HL: begin
          mem_we = 1'b1;
        end
        OP_LDS: begin
          next_ac = imm;
          load_ac = 1'b1;
          mem_we = 1'b1;
        end
        OP_LDA, OP_LDA_HL: begin
          next_ac = mem_rd;
          load_ac = 1'b1;
        end
        OP_LDH, OP_LDH_S: begin
          next_ac = table_data_i[TBL_W-1 -: DATA_W];
          load_ac = 1'b1;
          mem_we = 1'b1;
          hl_inc = (op == OP_LDH_S);
        end
        OP_LDL, OP_LDL_S: begin
          next_ac = table_data_i[DATA_W-1:0];
          load_ac = 1'b1;
          mem_we = 1'b1;
          hl_inc = (op == OP_LDL_S);
        end
        OP_COUNTER_NIBBLE0_READ, OP_COUNTER_NIBBLE1_READ, OP_COUNTER_NIBBLE2_READ, OP_COUNTER_NIBBLE3_READ: begin
          next_ac = nib(counter_i, op[1:0]);
          load_ac = 1'b1;
          mem_we = 1'b1;
        end
        OP_MSB: begin
          next_ac = {1'b0, wake_cause_flag_2, 2'b00};
          load_ac = 1'b1;
          mem_we = 1'b1;
        end
        OP_MSC: begin
          next_ac = {wake_cause_flag_7, prescaler_stage15_bit_i,
                     2'b00};
          load_ac = 1'b1;
          mem_we = 1'b1;
        end
        OP_MCX: begin
          next_ac = {wake_cause_flag_9, wake_cause_flag_0,
                     wake_cause_flag_6, 1'b0};
          load_ac = 1'b1;
          mem_we = 1'b1;
        end
        default: begin
          load_ac = 1'b0;
        end
      endcase
    end
  end

  assign mem_wdata = load_ac ? next_ac : four_bit_result_register;

  nibble_data_mem #(
    .AW(MEM_AW),
    .DW(DATA_W)
  ) u_mem (
    .clk_i(clk_i),
    .we_i(mem_we),
    .addr_i(mem_addr),
    .wdata_i(mem_wdata),
    .rdata_o(mem_rd)
  );

  // Sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      op <= OP_NOP;
      arg <= EN_RESET;
      imm <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (cmd_take) begin
            op <= cmd_op;
            arg <= wb_dat_i[CMD_ARG_LSB +: HL_W];
            imm <= wb_dat_i[CMD_IMM_LSB +: DATA_W];
            if (cmd_op == OP_HALT) begin
              state <= ST_HALT;
            end else if (cmd_op == OP_STOP) begin
              state <= ST_STOP;
            end else if (cmd_op != OP_NOP) begin
              state <= ST_FETCH;
            end
          end
        end
        ST_FETCH: begin
          state <= ST_EXEC;
        end
        ST_EXEC: begin
          state <= ST_IDLE;
        end
        ST_HALT: begin
          if (release_halt) begin
            state <= to_service ? ST_SERVICE : ST_IDLE;
          end
        end
        ST_SERVICE: begin
          if (irq_return_i) begin
            state <= ST_IDLE;
          end
        end
        ST_STOP: begin
          if (stop_wake_enable_flag && pin_s2) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Result register and index pointer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      four_bit_result_register <= '0;
      index_pointer <= EN_RESET;
    end else begin
      if (load_ac) begin
        four_bit_result_register <= next_ac;
      end
      if (hl_inc) begin
        index_pointer <= HL_W'(index_pointer + 1'b1);
      end else if (bus_wr && wb_adr_i == REG_HL && wb_sel_i[0] &&
                   state == ST_IDLE) begin
        index_pointer <= wb_dat_i[HL_W-1:0];
      end
    end
  end

  // Enable flags; reserved operand bits masked off
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_en <= EN_RESET;
      halt_en <= EN_RESET;
      sca_pin <= 1'b0;
      stop_wake_enable_flag <= 1'b0;
    end else if (state == ST_EXEC) begin
      case (op)
        OP_SIE: irq_en <= arg & IRQ_EN_MASK;
        OP_SHE: halt_en <= arg & HALT_EN_MASK;
        OP_SCA: sca_pin <= arg[WAKE_PIN_SEL_BIT];
        OP_SRE: stop_wake_enable_flag <= arg[WAKE_PIN_SEL_BIT];
        default: sca_pin <= sca_pin;
      endcase
    end
  end

  // Wake causes: cleared on halt entry, set by the releasing event
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_cause_flag_0 <= 1'b0;
      wake_cause_flag_2 <= 1'b0;
      wake_cause_flag_6 <= 1'b0;
      wake_cause_flag_7 <= 1'b0;
      wake_cause_flag_9 <= 1'b0;
    end else if (state == ST_HALT && release_halt) begin
      wake_cause_flag_0 <= hit_pin;
      wake_cause_flag_2 <= hit_pre | hit_tmr | hit_cnt;
      wake_cause_flag_6 <= hit_tmr;
      wake_cause_flag_7 <= hit_pre;
      wake_cause_flag_9 <= hit_cnt;
    end else if (cmd_take && cmd_op == OP_HALT) begin
      wake_cause_flag_0 <= 1'b0;
      wake_cause_flag_2 <= 1'b0;
      wake_cause_flag_6 <= 1'b0;
      wake_cause_flag_7 <= 1'b0;
      wake_cause_flag_9 <= 1'b0;
    end
  end

  assign table_addr_o = index_pointer;
  assign irq_req_o = (state == ST_SERVICE);
  assign osc_run_o = (state != ST_STOP);

  // Wishbone answer one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      if (bus_req && !wb_ack_o) begin
        wb_dat_o <= '0;
        case (wb_adr_i)
          REG_STATUS: begin
            wb_dat_o[STS_AC_LSB +: DATA_W] <= four_bit_result_register;
            wb_dat_o[STS_BUSY] <= (state == ST_FETCH || state == ST_EXEC);
            wb_dat_o[STS_HALT] <= (state == ST_HALT);
            wb_dat_o[STS_STOP] <= (state == ST_STOP);
            wb_dat_o[STS_SVC] <= (state == ST_SERVICE);
          end
          REG_HL: wb_dat_o[HL_W-1:0] <= index_pointer;
          REG_ENABLE: begin
            wb_dat_o[EN_IRQ_LSB +: HL_W] <= irq_en;
            wb_dat_o[EN_HALT_LSB +: HL_W] <= halt_en;
            wb_dat_o[EN_SCA] <= sca_pin;
            wb_dat_o[EN_SRE] <= stop_wake_enable_flag;
          end
          REG_WAKE: begin
            wb_dat_o[WK_F0] <= wake_cause_flag_0;
            wb_dat_o[WK_F2] <= wake_cause_flag_2;
            wb_dat_o[WK_F6] <= wake_cause_flag_6;
            wb_dat_o[WK_F7] <= wake_cause_flag_7;
            wb_dat_o[WK_F9] <= wake_cause_flag_9;
          end
          default: wb_dat_o <= '0;
        endcase
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ori_result: assert property (
    state == ST_EXEC && op == OP_ORI |=>
      four_bit_result_register == ($past(mem_rd) | $past(imm)))
    else $error("OR result wrong");
  a_ori_star_write: assert property (
    state == ST_EXEC && op == OP_ORI_S |->
      mem_we && mem_wdata == (mem_rd | imm) && mem_addr == arg[MEM_AW-1:0])
    else $error("starred OR write-back missing");
  a_store_indexed: assert property (
    state == ST_EXEC && op == OP_STA_HL |->
      mem_we && mem_addr == index_pointer[MEM_AW-1:0] &&
      mem_wdata == four_bit_result_register)
    else $error("indexed store wrong");
  a_load_imm: assert property (
    cmd_take && cmd_op == OP_LDS |=> ##1
      mem_we && mem_wdata == $past(wb_dat_i[CMD_IMM_LSB +: DATA_W], 2))
    else $error("load immediate wrong");
  a_table_inc: assert property (
    state == ST_EXEC && (op == OP_LDH_S || op == OP_LDL_S) |=>
      index_pointer == HL_W'($past(index_pointer) + 1'b1))
    else $error("index not incremented");
  a_counter_nibble: assert property (
    state == ST_EXEC && op == OP_COUNTER_NIBBLE2_READ |->
      mem_we && mem_wdata == counter_i[11:8])
    else $error("counter nibble wrong");
  a_halt_hold: assert property (
    state == ST_HALT && !release_halt |=> state == ST_HALT)
    else $error("halt left without cause");
  a_stop_osc: assert property (
    cmd_take && cmd_op == OP_STOP |=> !osc_run_o && state == ST_STOP)
    else $error("oscillator still running in stop");
  a_flag7_set: assert property (
    state == ST_HALT && hit_pre |=> wake_cause_flag_7 && wake_cause_flag_2)
    else $error("prescaler wake flag not set");
  a_reserved_bits: assert property (
    state == ST_EXEC && op == OP_SHE |=> (halt_en & ~HALT_EN_MASK) == '0)
    else $error("reserved enable bit stored");
endmodule // nibble_exec

// >>> tb/nibble_far_side.sv
`timescale 1ns/100ps
module nibble_far_side #(
  parameter logic [15:0] CNT = 16'h4C1D
) (
  input wire logic clk_i,
  input wire logic [7:0] table_addr_i,
  output logic [7:0] table_data_o,
  output logic [15:0] counter_o
);
  // Table word is its address mixed with a fixed pattern, one cycle late
  always_ff @(posedge clk_i) begin
    table_data_o <= table_addr_i ^ 8'h5A;
  end
  assign counter_o = CNT;
endmodule // nibble_far_side

// >>> tb/tb_top.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  n_fail++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module tb_top;
  import nibble_pkg::*;
  localparam logic [15:0] CNT = 16'h4C1D;
  logic clk_i, rst_i, cyc, stb, we, pre15, pre_ovf, tmr_unf, cnt_ovf;
  logic pin, irq_ret, irq_req, osc_run, ack;
  logic [7:0] adr, taddr, tdata;
  logic [3:0] sel, ac;
  logic [31:0] wdat, rdat, q;
  logic [15:0] cnt;
  int n_fail = 0;
  int n_checks = 0;

  nibble_exec i_nibble_exec (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .table_addr_o(taddr), .table_data_i(tdata), .counter_i(cnt),
    .prescaler_stage15_bit_i(pre15), .prescaler_ovf_i(pre_ovf),
    .timer_unf_i(tmr_unf), .counter_ovf_i(cnt_ovf),
    .wake_input_pin_i(pin), .irq_return_i(irq_ret), .irq_req_o(irq_req),
    .osc_run_o(osc_run));
  nibble_far_side #(.CNT(CNT)) i_nibble_far_side (.clk_i(clk_i),
    .table_addr_i(taddr), .table_data_o(tdata), .counter_o(cnt));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic lim(input int k);
    if (k >= 100) begin
      n_fail++;
      end_sim();
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 100);
    lim(k);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  // Wait until one status bit reaches a level
  task automatic poll(input int b, input logic v);
    int k;
    k = 0;
    do begin
      bus(1'b0, REG_STATUS, 32'h0);
      k++;
    end while (q[b] !== v && k < 100);
    lim(k);
    ac = q[3:0];
  endtask

  task automatic idle();
    int k;
    k = 0;
    do begin
      bus(1'b0, REG_STATUS, 32'h0);
      k++;
    end while (q[7:4] !== 4'h0 && k < 100);
    lim(k);
    ac = q[3:0];
  endtask

  task automatic cmd(input logic [4:0] o, input logic [7:0] x,
    input logic [3:0] d);
    bus(1'b1, REG_CMD, {12'h0, d, x, 3'h0, o});
    if (o != OP_HALT && o != OP_STOP) idle();
  endtask

  task automatic t_enable();
    bus(1'b0, REG_ENABLE, 32'h0);
    `CHK("en reset", 32'h0, q)
    cmd(OP_SIE, 8'hFF, 4'h0);
    cmd(OP_SHE, 8'hFF, 4'h0);
    cmd(OP_SCA, 8'hEF, 4'h0);
    bus(1'b0, REG_ENABLE, 32'h0);
    `CHK("en all", 32'h0000_5859, q)
    cmd(OP_SCA, 8'h10, 4'h0);
    cmd(OP_SRE, 8'h10, 4'h0);
    bus(1'b0, REG_ENABLE, 32'h0);
    `CHK("en wake", 32'h0003_5859, q)
    cmd(OP_SIE, 8'hA6, 4'h0);
    cmd(OP_SHE, 8'hA7, 4'h0);
    cmd(OP_SRE, 8'hEF, 4'h0);
    bus(1'b0, REG_ENABLE, 32'h0);
    `CHK("en reserved", 32'h0001_0000, q)
    bus(1'b0, 8'h14, 32'h0);
    `CHK("unmapped", 32'h0, q)
    sel <= 4'h1;
    bus(1'b1, REG_CMD, {24'h00FF_00, 3'h0, OP_SIE});
    sel <= 4'hF;
    idle();
    bus(1'b0, REG_ENABLE, 32'h0);
    `CHK("cmd part sel", 32'h0001_0000, q)
    $display("done enable");
  endtask

  task automatic t_load();
    cmd(OP_LDS, 8'h05, 4'hA);
    `CHK("lds ac", 4'hA, ac)
    cmd(OP_ORI, 8'h05, 4'h5);
    `CHK("ori ac", 4'hF, ac)
    cmd(OP_LDA, 8'h05, 4'h0);
    `CHK("ori mem", 4'hA, ac)
    cmd(OP_ORI_S, 8'h05, 4'h4);
    `CHK("ori* ac", 4'hE, ac)
    cmd(OP_LDS, 8'h06, 4'h0);
    cmd(OP_LDA, 8'h05, 4'h0);
    `CHK("ori* mem", 4'hE, ac)
    cmd(OP_STA, 8'h09, 4'h0);
    bus(1'b1, REG_HL, 32'h9);
    cmd(OP_LDS, 8'h06, 4'h3);
    cmd(OP_LDA_HL, 8'h00, 4'h0);
    `CHK("lda idx", 4'hE, ac)
    cmd(OP_LDS, 8'h06, 4'h3);
    cmd(OP_STA_HL, 8'h00, 4'h0);
    cmd(OP_LDS, 8'h06, 4'h0);
    cmd(OP_LDA, 8'h09, 4'h0);
    `CHK("sta idx", 4'h3, ac)
    $display("done load");
  endtask

  task automatic t_table();
    bus(1'b1, REG_HL, 32'h10);
    cmd(OP_LDH, 8'h14, 4'h0);
    `CHK("ldh ac", 4'h4, ac)
    cmd(OP_LDS, 8'h06, 4'h0);
    cmd(OP_LDA, 8'h14, 4'h0);
    `CHK("ldh mem", 4'h4, ac)
    cmd(OP_LDL, 8'h14, 4'h0);
    `CHK("ldl ac", 4'hA, ac)
    cmd(OP_LDH_S, 8'h14, 4'h0);
    bus(1'b0, REG_HL, 32'h0);
    `CHK("ldh* hl", 32'h11, q)
    cmd(OP_LDL_S, 8'h14, 4'h0);
    `CHK("ldl* ac", 4'hB, ac)
    bus(1'b1, REG_HL, 32'hFF);
    cmd(OP_LDL_S, 8'h14, 4'h0);
    `CHK("ldl* top", 4'h5, ac)
    bus(1'b0, REG_HL, 32'h0);
    `CHK("ldl* wrap", 32'h0, q)
    $display("done table");
  endtask

  task automatic t_count();
    for (int k = 0; k < 4; k++) begin
      cmd(5'h0C + 5'(k), 8'h20, 4'h0);
      `CHK("cnt nibble", CNT[4*k +: 4], ac)
    end
    $display("done count");
  endtask

  task automatic t_halt_pre();
    cmd(OP_SCA, 8'h00, 4'h0);
    cmd(OP_SHE, 8'h08, 4'h0);
    cmd(OP_SIE, 8'h00, 4'h0);
    pre15 <= 1'b1;
    cmd(OP_HALT, 8'h00, 4'h0);
    poll(STS_HALT, 1'b1);
    cnt_ovf <= 1'b1;
    @(posedge clk_i);
    cnt_ovf <= 1'b0;
    repeat (4) @(posedge clk_i);
    bus(1'b0, REG_STATUS, 32'h0);
    `CHK("halt held", 1'b1, q[STS_HALT])
    pre_ovf <= 1'b1;
    @(posedge clk_i);
    pre_ovf <= 1'b0;
    idle();
    bus(1'b0, REG_WAKE, 32'h0);
    `CHK("wake pre", 32'h84, q)
    cmd(OP_MSC, 8'h21, 4'h0);
    `CHK("flag c", 4'hC, ac)
    cmd(OP_MSB, 8'h21, 4'h0);
    `CHK("flag b", 4'h4, ac)
    cmd(OP_MCX, 8'h21, 4'h0);
    `CHK("flag x", 4'h0, ac)
    $display("done halt prescaler");
  endtask

  task automatic t_halt_irq();
    cmd(OP_SHE, 8'h10, 4'h0);
    cmd(OP_SIE, 8'h10, 4'h0);
    cmd(OP_HALT, 8'h00, 4'h0);
    poll(STS_HALT, 1'b1);
    tmr_unf <= 1'b1;
    @(posedge clk_i);
    tmr_unf <= 1'b0;
    poll(STS_SVC, 1'b1);
    `CHK("irq req", 1'b1, irq_req)
    irq_ret <= 1'b1;
    @(posedge clk_i);
    irq_ret <= 1'b0;
    idle();
    `CHK("irq done", 1'b0, irq_req)
    cmd(OP_MCX, 8'h22, 4'h0);
    `CHK("flag x tmr", 4'h2, ac)
    cmd(OP_MSB, 8'h22, 4'h0);
    `CHK("flag b tmr", 4'h4, ac)
    $display("done halt irq");
  endtask

  task automatic t_pin_stop();
    cmd(OP_SHE, 8'h00, 4'h0);
    cmd(OP_SIE, 8'h00, 4'h0);
    cmd(OP_SCA, 8'h10, 4'h0);
    cmd(OP_HALT, 8'h00, 4'h0);
    poll(STS_HALT, 1'b1);
    pin <= 1'b1;
    idle();
    cmd(OP_MCX, 8'h23, 4'h0);
    `CHK("flag x pin", 4'h4, ac)
    pin <= 1'b0;
    cmd(OP_SRE, 8'h10, 4'h0);
    cmd(OP_STOP, 8'h00, 4'h0);
    poll(STS_STOP, 1'b1);
    `CHK("osc off", 1'b0, osc_run)
    pin <= 1'b1;
    poll(STS_STOP, 1'b0);
    `CHK("osc on", 1'b1, osc_run)
    pin <= 1'b0;
    $display("done pin stop");
  endtask

  initial begin
    {rst_i, cyc, stb, we, pre15, pre_ovf} = 6'b100000;
    {tmr_unf, cnt_ovf, pin, irq_ret} = 4'h0;
    adr = 8'h00;
    wdat = 32'h0;
    sel = 4'hF;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_enable();
    t_load();
    t_table();
    t_count();
    t_halt_pre();
    t_halt_irq();
    t_pin_stop();
    end_sim();
  end
endmodule // tb_top
